// file: agc_amp_model.sv
// Behavioural amplifier and peak comparators beside the gain controller.
// Assumes levels in 0.5 dB units and comparators that settle every mclk.
`timescale 1ns/100ps
`default_nettype none

module agc_amp_model #(
    parameter int THR_HI = 64,
    parameter int HYST = 6
) (
    input wire logic mclk,
    input wire logic [6:0] gain_code,
    input wire logic [7:0] sig_level,
    output logic above_upper,
    output logic below_lower
);
    int out_level;

    // Output level is input level plus applied gain; 3 dB is six steps
    assign out_level = int'(sig_level) + int'(gain_code);

    always_ff @(posedge mclk) begin
        above_upper <= out_level > THR_HI;
        below_lower <= out_level < THR_HI - HYST;
    end
endmodule : agc_amp_model

`default_nettype wire

// file: agc_gain_controller.sv
// Gain controller for the microphone amplifier and compressor.
// Assumes comparator flags and converter words synchronous to mclk.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

module agc_gain_controller
    import agc_pkg::*;
#(
    parameter int GAIN_W = 7,
    parameter int HOLD_LONG = HOLD_LONG_TICKS,
    parameter int HOLD_SHORT = HOLD_SHORT_TICKS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire agc_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic above_upper,
    input wire logic below_lower,
    input wire logic [15:0] adc_data,
    output logic [GAIN_W-1:0] gain_code,
    output logic mod_tick,
    output logic sample_strobe,
    output logic [15:0] adc_word
);

    localparam int HOLD_W = 17;
    localparam int PER_W = 11;

    if (GAIN_W != 7) begin : g_bad_width
        $error("GAIN_W must be 7");
    end
    if (HOLD_LONG < 1 || HOLD_LONG >= 2 ** HOLD_W || HOLD_SHORT < 1
        || HOLD_SHORT > HOLD_LONG) begin : g_bad_hold
        $error("hold counts out of range");
    end

    function automatic logic [PER_W-1:0] rate_period(input logic [2:0] sel);
        rate_period = PER_W'(STEP_BASE_TICKS) << sel;
    endfunction : rate_period

    ////////////////////////////////////////////////////////////////////////
    // Control tick and converter timing
    logic [15:0] tick_acc;
    logic [4:0] sample_cnt;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tick_acc <= 16'h0000;
            mod_tick <= 1'b0;
        end else if (tick_acc >= MCLK_KHZ - SYS_CLK_KHZ) begin
            tick_acc <= tick_acc - (MCLK_KHZ - SYS_CLK_KHZ);
            mod_tick <= 1'b1;
        end else begin
            tick_acc <= tick_acc + SYS_CLK_KHZ;
            mod_tick <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sample_cnt <= 5'h00;
            sample_strobe <= 1'b0;
            adc_word <= 16'h0000;
        end else begin
            sample_strobe <= 1'b0;
            if (mod_tick) begin
                if (sample_cnt == 5'(TICKS_PER_SAMPLE - 1)) begin
                    sample_cnt <= 5'h00;
                    sample_strobe <= 1'b1;
                    adc_word <= adc_data;
                end else begin
                    sample_cnt <= sample_cnt + 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    agc_mode_t cfg_mode;
    logic cfg_hold_short;
    logic [7:0] gain_set;
    logic [7:0] fast_sel;
    logic [7:0] slow_sel;
    logic [GAIN_W-1:0] max_gain;

    assign max_gain = gain_set[GAIN_W-1:0];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg_mode <= AGC_MODE_DUAL;
            cfg_hold_short <= HOLD_RESET;
            gain_set <= GAIN_RESET;
            fast_sel <= RATE_RESET;
            slow_sel <= RATE_RESET;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                ADDR_CONFIG: begin
                    cfg_mode <= agc_mode_t'(
                        bus_req.wdata[CFG_MODE_MSB:CFG_MODE_LSB]);
                    cfg_hold_short <= bus_req.wdata[CFG_HOLD_BIT];
                end
                ADDR_GAIN: gain_set <= bus_req.wdata;
                ADDR_FAST_RATE: fast_sel <= bus_req.wdata;
                ADDR_SLOW_RATE: slow_sel <= bus_req.wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_CONFIG: rdata <= {3'h0, cfg_hold_short, cfg_mode, 2'h0};
                ADDR_GAIN: rdata <= gain_set[GAIN_READ_BIT]
                    ? {1'b1, gain_code} : gain_set;
                ADDR_FAST_RATE: rdata <= fast_sel;
                ADDR_SLOW_RATE: rdata <= slow_sel;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hold timer before a gain increase in dual and single-rate modes
    logic [HOLD_W-1:0] hold_cnt;
    logic hold_done;

    assign hold_done = hold_cnt >= (cfg_hold_short ? HOLD_W'(HOLD_SHORT)
        : HOLD_W'(HOLD_LONG));

    always_ff @(posedge mclk) begin
        if (!nrst || !below_lower) begin
            hold_cnt <= '0;
        end else if (mod_tick && !hold_done) begin
            hold_cnt <= hold_cnt + HOLD_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fast-rate counter
    logic [GAIN_W-1:0] gain_fast;
    logic fast_up;
    logic fast_dn;
    logic [PER_W-1:0] fast_period;
    logic [PER_W-1:0] fast_timer;
    logic fast_step;
    logic auto_mode;

    assign auto_mode = cfg_mode == AGC_MODE_DUAL
        || cfg_mode == AGC_MODE_SINGLE;

    always_comb begin
        fast_up = 1'b0;
        fast_dn = 1'b0;
        unique case (cfg_mode)
            AGC_MODE_DUAL, AGC_MODE_SINGLE: begin
                if (gain_fast > max_gain) begin
                    fast_dn = 1'b1;
                end else if (above_upper) begin
                    fast_dn = gain_fast != '0;
                end else if (below_lower && hold_done) begin
                    fast_up = gain_fast < max_gain;
                end
            end
            AGC_MODE_STEPPED: begin
                fast_up = gain_fast < max_gain;
                fast_dn = gain_fast > max_gain;
            end
            AGC_MODE_IMMEDIATE: begin
            end
        endcase
    end

    assign fast_period = fast_dn
        ? rate_period(fast_sel[RATE_ATK_LSB+:3])
        : rate_period(fast_sel[RATE_REL_LSB+:3]);
    assign fast_step = mod_tick && (fast_up || fast_dn)
        && fast_timer >= fast_period - PER_W'(1);

    always_ff @(posedge mclk) begin
        if (!nrst || !(fast_up || fast_dn) || fast_step) begin
            fast_timer <= '0;
        end else if (mod_tick) begin
            fast_timer <= fast_timer + PER_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gain_fast <= '0;
        end else if (cfg_mode == AGC_MODE_IMMEDIATE) begin
            gain_fast <= max_gain;
        end else if (fast_step) begin
            gain_fast <= fast_dn ? gain_fast - GAIN_W'(1)
                : gain_fast + GAIN_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow-rate counter
    logic [GAIN_W-1:0] gain_slow;
    logic slow_up;
    logic slow_dn;
    logic [PER_W-1:0] slow_period;
    logic [PER_W-1:0] slow_timer;
    logic slow_step;

    assign slow_up = cfg_mode == AGC_MODE_DUAL && gain_slow < gain_fast;
    assign slow_dn = cfg_mode == AGC_MODE_DUAL && gain_slow > gain_fast;
    assign slow_period = slow_dn
        ? rate_period(slow_sel[RATE_ATK_LSB+:3])
        : rate_period(slow_sel[RATE_REL_LSB+:3]);
    assign slow_step = mod_tick && (slow_up || slow_dn)
        && slow_timer >= slow_period - PER_W'(1);

    always_ff @(posedge mclk) begin
        if (!nrst || !(slow_up || slow_dn) || slow_step) begin
            slow_timer <= '0;
        end else if (mod_tick) begin
            slow_timer <= slow_timer + PER_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gain_slow <= '0;
        end else if (cfg_mode != AGC_MODE_DUAL) begin
            gain_slow <= gain_fast;
        end else if (slow_step) begin
            gain_slow <= slow_dn ? gain_slow - GAIN_W'(1)
                : gain_slow + GAIN_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Applied gain
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gain_code <= '0;
        end else if (cfg_mode == AGC_MODE_DUAL && gain_slow < gain_fast) begin
            gain_code <= gain_slow;
        end else begin
            gain_code <= gain_fast;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence fast_moved;
        cfg_mode != AGC_MODE_IMMEDIATE && $changed(gain_fast);
    endsequence
    sequence fast_rests;
        $stable(gain_fast) [*8];
    endsequence
    sequence imm_held;
        (cfg_mode == AGC_MODE_IMMEDIATE) [*2];
    endsequence

    mode_reset_a: assert property ($past(!nrst) |->
        cfg_mode == AGC_MODE_DUAL) else $error("mode not dual after reset");
    attack_cause_a: assert property (
        auto_mode && $past(auto_mode) && gain_fast < $past(gain_fast) |->
        $past(above_upper) || $past(gain_fast) > $past(max_gain))
        else $error("gain fell without cause");
    release_cap_a: assert property (
        auto_mode && $past(auto_mode) && gain_fast > $past(gain_fast) |->
        gain_fast <= $past(max_gain)) else $error("gain rose above set gain");
    release_hold_a: assert property (
        auto_mode && $past(auto_mode) && gain_fast > $past(gain_fast) |->
        $past(hold_done) && $past(below_lower))
        else $error("gain rose before hold period");
    slow_track_a: assert property (
        cfg_mode == AGC_MODE_DUAL && $past(cfg_mode == AGC_MODE_DUAL)
        && $changed(gain_slow) |->
        (gain_slow > $past(gain_slow)) == ($past(gain_fast)
        > $past(gain_slow))) else $error("slow counter moved away");
    dual_min_a: assert property (cfg_mode == AGC_MODE_DUAL |->
        ##1 gain_code <= $past(gain_fast) && gain_code <= $past(gain_slow))
        else $error("applied gain not the minimum");
    step_spacing_a: assert property (fast_moved |=> fast_rests)
        else $error("fast steps too close");
    single_follow_a: assert property (
        cfg_mode == AGC_MODE_SINGLE |=> gain_code == $past(gain_fast))
        else $error("single-rate gain not fast counter");
    stepped_unit_a: assert property (
        cfg_mode == AGC_MODE_STEPPED && $past(cfg_mode) == AGC_MODE_STEPPED
        |-> gain_fast == $past(gain_fast)
        || gain_fast == $past(gain_fast) + GAIN_W'(1)
        || gain_fast == $past(gain_fast) - GAIN_W'(1))
        else $error("stepped mode skipped a step");
    immediate_a: assert property (
        imm_held |=> gain_code == $past(max_gain, 2))
        else $error("immediate gain not applied");
    live_read_a: assert property (
        bus_req.rd && bus_req.addr == ADDR_GAIN && gain_set[GAIN_READ_BIT]
        |=> rdata == {1'b1, $past(gain_code)})
        else $error("live gain read wrong");
    tick_gap_a: assert property (mod_tick |=> !mod_tick [*8])
        else $error("control tick too fast");
    hold_restart_a: assert property (
        !below_lower |=> hold_cnt == '0)
        else $error("hold timer not restarted");

endmodule : agc_gain_controller

`default_nettype wire

// file: agc_gain_controller_test.sv
// Self-checking bench for the gain controller and its amplifier model.
// Assumes agc_pkg is compiled first and mclk runs at 50 MHz.
`timescale 1ns/100ps
`default_nettype none

module agc_gain_controller_test;
    import agc_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    agc_bus_req_t bus_req = '0;
    logic [7:0] rdata;
    logic above_upper;
    logic below_lower;
    logic [15:0] adc_data = 16'h0000;
    logic [6:0] gain_code;
    logic mod_tick;
    logic sample_strobe;
    logic [15:0] adc_word;
    logic [7:0] sig_level = 8'h00;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 4;

    always #10 mclk = ~mclk;

    agc_gain_controller #(.GAIN_W(7), .HOLD_LONG(20), .HOLD_SHORT(10)) dut_u (
        .mclk(mclk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
        .above_upper(above_upper), .below_lower(below_lower),
        .adc_data(adc_data), .gain_code(gain_code), .mod_tick(mod_tick),
        .sample_strobe(sample_strobe), .adc_word(adc_word));

    agc_amp_model amp_u (.mclk(mclk), .gain_code(gain_code),
        .sig_level(sig_level), .above_upper(above_upper),
        .below_lower(below_lower));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what,
                got, exp);
        end
    endtask : check

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp,
                          input string what);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp}, what);
    endtask : rd_chk

    // Follows the gain to a target, flagging any jump larger than one step
    task automatic wait_gain(input logic [6:0] exp, input int bound);
        logic [6:0] prev;
        prev = gain_code;
        for (int k = 0; k < bound && gain_code !== exp; k++) begin
            @(posedge mclk);
            #1;
            if (gain_code !== prev && gain_code !== prev + 7'h01
                && gain_code !== prev - 7'h01) begin
                check({9'h000, gain_code}, {9'h000, prev}, "gain jumped");
            end
            prev = gain_code;
        end
        check({9'h000, gain_code}, {9'h000, exp}, "gain target");
        if (gain_code !== exp) begin
            results();
        end
    endtask : wait_gain

    task automatic hold_chk(input logic [6:0] exp, input int cycles);
        repeat (cycles) @(posedge mclk);
        #1;
        check({9'h000, gain_code}, {9'h000, exp}, "gain held");
    endtask : hold_chk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        int n;
        int ticks;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd_chk(a[2:0], 8'h00, "reset read");
        end
        check({9'h000, gain_code}, 16'h0000, "reset gain");
        wr_reg(ADDR_CONFIG, 8'hFF);
        rd_chk(ADDR_CONFIG, 8'h1C, "config fields");
        $display("Reset and config test done");

        wr_reg(ADDR_CONFIG, 8'h0C);
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed)) & 8'h7F;
            wr_reg(ADDR_GAIN, v);
            repeat (3) @(posedge mclk);
            #1;
            check({9'h000, gain_code}, {8'h00, v}, "immediate gain");
            rd_chk(ADDR_GAIN, v, "stored gain");
            v = 8'($random(seed)) & 8'h77;
            wr_reg(ADDR_SLOW_RATE, v);
            rd_chk(ADDR_SLOW_RATE, v, "slow rate");
        end
        wr_reg(ADDR_FAST_RATE, 8'h00);
        wr_reg(ADDR_GAIN, 8'h20);
        $display("Immediate mode test done");

        wr_reg(ADDR_CONFIG, 8'h08);
        wr_reg(ADDR_GAIN, 8'hA4);
        rd_chk(ADDR_GAIN, 8'hA0, "live gain read");
        wait_gain(7'h24, 2000);
        wr_reg(ADDR_GAIN, 8'h26);
        wait_gain(7'h25, 400);
        n = 0;
        while (n < 400 && gain_code === 7'h25) begin
            @(posedge mclk);
            #1;
            n++;
        end
        // Eight control ticks per 0.5 dB step is 312.5 mclk cycles
        check(16'(n >= 312 && n <= 313), 16'h0001, "step period");
        $display("Stepped mode test done");

        wr_reg(ADDR_GAIN, 8'h30);
        wr_reg(ADDR_CONFIG, 8'h14);
        sig_level <= 8'd40;
        wait_gain(7'h18, 8000);
        hold_chk(7'h18, 2000);
        sig_level <= 8'd0;
        wait_gain(7'h30, 12000);
        hold_chk(7'h30, 1000);
        $display("Single-rate test done");

        wr_reg(ADDR_SLOW_RATE, 8'h77);
        wr_reg(ADDR_CONFIG, 8'h00);
        sig_level <= 8'd40;
        wait_gain(7'h18, 8000);
        // Fast slow rates let the slow counter catch the fast one
        wr_reg(ADDR_SLOW_RATE, 8'h00);
        hold_chk(7'h18, 8000);
        // Slow release now keeps the gain down while the fast counter climbs
        wr_reg(ADDR_SLOW_RATE, 8'h77);
        sig_level <= 8'd0;
        hold_chk(7'h18, 3000);
        $display("Dual-rate test done");

        @(posedge mclk);
        adc_data <= 16'($random(seed));
        n = 0;
        while (n < 1400 && sample_strobe !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
        end
        n = 0;
        ticks = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
            ticks += (mod_tick === 1'b1);
        end while (n < 1400 && sample_strobe !== 1'b1);
        check(16'(n >= 1249 && n <= 1251), 16'h0001, "word period");
        check(16'(ticks), 16'd32, "ticks per word");
        repeat (2) @(posedge mclk);
        #1;
        check(adc_word, adc_data, "converter word");
        $display("Converter test done");
        results();
    end
endmodule : agc_gain_controller_test

`default_nettype wire

// file: agc_pkg.sv
// Shared constants, field layouts and types for the gain controller.
// Assumes a 50 MHz register clock and a 1.28 MHz control tick made from it.
package agc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses on the plain register port)
    localparam logic [2:0] ADDR_CONFIG = 3'h0;
    localparam logic [2:0] ADDR_GAIN = 3'h1;
    localparam logic [2:0] ADDR_FAST_RATE = 3'h2;
    localparam logic [2:0] ADDR_SLOW_RATE = 3'h3;

    // Configuration register fields
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_MODE_MSB = 3;
    localparam int CFG_HOLD_BIT = 4;
    // Gain setting register fields
    localparam int GAIN_READ_BIT = 7;
    // Rate select fields: attack in low bits, release in high bits
    localparam int RATE_ATK_LSB = 0;
    localparam int RATE_REL_LSB = 4;

    // Reset values
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic HOLD_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam logic [15:0] MCLK_KHZ = 16'hC350;
    localparam logic [15:0] SYS_CLK_KHZ = 16'h0500;
    localparam int HOLD_LONG_MS = 50;
    localparam int HOLD_SHORT_MS = 25;
    localparam int HOLD_LONG_TICKS = HOLD_LONG_MS * int'(SYS_CLK_KHZ);
    localparam int HOLD_SHORT_TICKS = HOLD_SHORT_MS * int'(SYS_CLK_KHZ);
    localparam int FIXED_RATE_KDB_S = 80;
    localparam int GAIN_STEP_MDB = 500;
    // Ticks per 0.5 dB step at 80 KdB/s
    localparam int STEP_BASE_TICKS = int'(SYS_CLK_KHZ) * GAIN_STEP_MDB
        / (FIXED_RATE_KDB_S * 1000);
    localparam int OVERSAMPLE = 64;
    localparam int SAMPLE_KHZ = 40;
    localparam int TICKS_PER_SAMPLE = int'(SYS_CLK_KHZ) / SAMPLE_KHZ;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        AGC_MODE_DUAL = 2'h0,
        AGC_MODE_SINGLE = 2'h1,
        AGC_MODE_STEPPED = 2'h2,
        AGC_MODE_IMMEDIATE = 2'h3
    } agc_mode_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } agc_bus_req_t;

endpackage : agc_pkg
